// ---- rtl/iio_pkg.sv ----
// Overview of operation
// - Eight isolated inputs are synchronised and their filtered state is readable.
// - Each input has its own filter enable and duration set by software.
// - An enabled filter holds the reported state until the new level persists.
// - Filter duration is N (2 to 65535) times 5 ms plus up to 5 ms.
// - A selected subset of inputs matching a preset pattern raises an interrupt.
// - Any monitored input changing state raises a change-of-state interrupt.
// - Each input has its own 16-bit up-counting event counter.
// - Each event counter adds one on every rising and every falling transition.
// - Counters keep up with inputs to 500 Hz with 1 ms phases while the input's filter is disabled.
// - Counter overflow or reaching a preset compare value raises an interrupt.
// - Two pulse outputs with 16-bit high and low periods in 100 ms steps.
// - Each period is count 1 to 65535 times 100 ms, exact to the clock cycle.
// - Eight software-controlled on/off outputs each drive one relay.
package iio_pkg;

   localparam int NCH          = 8;
   localparam int NPWM         = 2;
   localparam int CLK_HZ       = 50_000_000;
   localparam int FILT_STEP_MS = 5;
   localparam int PWM_STEP_MS  = 100;
   localparam int FILT_TICK_CYC = (CLK_HZ / 1000) * FILT_STEP_MS;
   localparam int PWM_TICK_CYC  = (CLK_HZ / 1000) * PWM_STEP_MS;

   localparam logic [15:0] FILT_MIN_N = 16'h0002;
   localparam logic [15:0] FILT_RST_N = 16'h0002;
   localparam logic [15:0] PWM_MIN_N  = 16'h0001;
   localparam logic [15:0] PWM_RST_N  = 16'h0001;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;

   localparam logic [7:0] OFS_DI_STATE = 8'h00;
   localparam logic [7:0] OFS_FILT_EN  = 8'h04;
   localparam logic [7:0] OFS_PAT_MASK = 8'h08;
   localparam logic [7:0] OFS_PAT_VAL  = 8'h0C;
   localparam logic [7:0] OFS_COS_EN   = 8'h10;
   localparam logic [7:0] OFS_RELAY    = 8'h14;
   localparam logic [7:0] OFS_INT_STAT = 8'h18;
   localparam logic [7:0] OFS_INT_MASK = 8'h1C;
   localparam logic [7:0] OFS_PWM_CTRL = 8'h20;
   localparam logic [7:0] OFS_PWM_A    = 8'h24;
   localparam logic [7:0] OFS_PWM_B    = 8'h28;
   // Per-channel banks: byte address bits 7:5 select the bank, bits 4:2 the channel.
   localparam logic [2:0] BANK_FILT_N  = 3'h2;
   localparam logic [2:0] BANK_EV_CMP  = 3'h3;
   localparam logic [2:0] BANK_EV_CNT  = 3'h4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] rsv_hi;
      logic [7:0] cmp;
      logic [7:0] ovf;
      logic [5:0] rsv_lo;
      logic       cos;
      logic       pat;
   } iio_irq_t;

   typedef struct packed {
      logic [15:0] low_n;
      logic [15:0] high_n;
   } iio_pwm_cfg_t;

   typedef enum logic [1:0] {
      PW_IDLE = 2'h0,
      PW_HIGH = 2'h1,
      PW_LOW  = 2'h3
   } iio_pwm_st_t;

endpackage

// ---- rtl/iio_top.sv ----
`timescale 1ns/1ps
module iio_top #(
   parameter int FILT_TICK_CYC = iio_pkg::FILT_TICK_CYC,
   parameter int PWM_TICK_CYC  = iio_pkg::PWM_TICK_CYC
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic [7:0]  S_AXI_AWADDR_I,
   input  wire logic        S_AXI_AWVALID_I,
   output logic             S_AXI_AWREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   input  wire logic        S_AXI_WVALID_I,
   output logic             S_AXI_WREADY_O,
   output logic [1:0]       S_AXI_BRESP_O,
   output logic             S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   input  wire logic [7:0]  S_AXI_ARADDR_I,
   input  wire logic        S_AXI_ARVALID_I,
   output logic             S_AXI_ARREADY_O,
   output logic [31:0]      S_AXI_RDATA_O,
   output logic [1:0]       S_AXI_RRESP_O,
   output logic             S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I,
   input  wire logic [7:0]  ISO_IN_I,
   output logic [7:0]       RELAY_O,
   output logic             PULSE_OUT_A_O,
   output logic             PULSE_OUT_B_O,
   output logic             IRQ_O
);

   localparam logic [31:0] FTICK_LAST = 32'(FILT_TICK_CYC - 1);
   localparam logic [31:0] PTICK_LAST = 32'(PWM_TICK_CYC - 1);

   function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] at_least(input logic [15:0] n, input logic [15:0] lo);
      return (n < lo) ? lo : n;
   endfunction

   logic [7:0]               sync1_q;
   logic [7:0]               sync2_q;
   logic [7:0]               di_q;
   logic [7:0]               di_d;
   logic [16:0]              fcnt_q [iio_pkg::NCH];
   logic [16:0]              fcnt_d [iio_pkg::NCH];
   logic [31:0]              fpre_q;
   logic [31:0]              fpre_d;
   logic                     ftick;
   logic [15:0]              fdur_q [iio_pkg::NCH];
   logic [15:0]              fdur_d [iio_pkg::NCH];
   logic [15:0]              ecmp_q [iio_pkg::NCH];
   logic [15:0]              ecmp_d [iio_pkg::NCH];
   logic [15:0]              ecnt_q [iio_pkg::NCH];
   logic [15:0]              ecnt_d [iio_pkg::NCH];
   logic [7:0]               fen_q;
   logic [7:0]               fen_d;
   logic [7:0]               pmask_q;
   logic [7:0]               pmask_d;
   logic [7:0]               pval_q;
   logic [7:0]               pval_d;
   logic [7:0]               cos_en_q;
   logic [7:0]               cos_en_d;
   logic [7:0]               relay_q;
   logic [7:0]               relay_d;
   logic                     match_q;
   logic                     match_d;
   iio_pkg::iio_irq_t        st_q;
   iio_pkg::iio_irq_t        st_d;
   iio_pkg::iio_irq_t        ien_q;
   iio_pkg::iio_irq_t        ien_d;
   iio_pkg::iio_irq_t        ev;
   logic [1:0]               pwm_en_q;
   logic [1:0]               pwm_en_d;
   iio_pkg::iio_pwm_cfg_t    pcfg_q [iio_pkg::NPWM];
   iio_pkg::iio_pwm_cfg_t    pcfg_d [iio_pkg::NPWM];
   iio_pkg::iio_pwm_st_t     pst_q [iio_pkg::NPWM];
   iio_pkg::iio_pwm_st_t     pst_d [iio_pkg::NPWM];
   logic [15:0]              pcnt_q [iio_pkg::NPWM];
   logic [15:0]              pcnt_d [iio_pkg::NPWM];
   logic [31:0]              ppre_q [iio_pkg::NPWM];
   logic [31:0]              ppre_d [iio_pkg::NPWM];
   logic [1:0]               pout_q;
   logic [1:0]               pout_d;
   logic                     bvalid_q;
   logic                     bvalid_d;
   logic [1:0]               bresp_q;
   logic [1:0]               bresp_d;
   logic                     rvalid_q;
   logic                     rvalid_d;
   logic [1:0]               rresp_q;
   logic [1:0]               rresp_d;
   logic [31:0]              rdata_q;
   logic [31:0]              rdata_d;
   logic                     wr_hs;
   logic                     rd_hs;
   logic [7:0]               wa;
   logic [7:0]               ra;
   logic [7:0]               chg;

   // Write address and data are taken together; a pending response blocks the next write.
   assign wr_hs           = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~bvalid_q;
   assign rd_hs           = S_AXI_ARVALID_I & ~rvalid_q;
   assign S_AXI_AWREADY_O = wr_hs;
   assign S_AXI_WREADY_O  = wr_hs;
   assign S_AXI_ARREADY_O = ~rvalid_q;
   assign S_AXI_BVALID_O  = bvalid_q;
   assign S_AXI_BRESP_O   = bresp_q;
   assign S_AXI_RVALID_O  = rvalid_q;
   assign S_AXI_RRESP_O   = rresp_q;
   assign S_AXI_RDATA_O   = rdata_q;
   assign wa              = {S_AXI_AWADDR_I[7:2], 2'h0};
   assign ra              = {S_AXI_ARADDR_I[7:2], 2'h0};
   assign RELAY_O         = relay_q;
   assign PULSE_OUT_A_O   = pout_q[0];
   assign PULSE_OUT_B_O   = pout_q[1];
   assign IRQ_O           = |(st_q & ien_q);
   assign ftick           = (fpre_q == FTICK_LAST);

   // Input filters and the 5 ms prescaler.
   always_comb begin
      fpre_d = ftick ? '0 : fpre_q + 32'h1;
      for (int c = 0; c < iio_pkg::NCH; c++) begin
         fcnt_d[c] = '0;
         di_d[c]   = di_q[c];
         if (!fen_q[c]) begin
            di_d[c] = sync2_q[c];
         end else if (sync2_q[c] != di_q[c]) begin
            // The level must survive N+1 prescaler ticks, the first of them possibly partial, before it is reported.
            if (fcnt_q[c] >= {1'b0, at_least(fdur_q[c], iio_pkg::FILT_MIN_N)} + 17'h1) begin
               di_d[c] = sync2_q[c];
            end else begin
               fcnt_d[c] = fcnt_q[c] + {16'h0, ftick};
            end
         end
      end
   end

   // Event detection, counters and software-visible registers.
   always_comb begin
      chg     = di_d ^ di_q;
      match_d = (pmask_q != '0) && (((di_d ^ pval_q) & pmask_q) == '0);
      ev      = '0;
      ev.pat  = match_d & ~match_q;
      ev.cos  = |(chg & cos_en_q);
      fen_d    = fen_q;
      pmask_d  = pmask_q;
      pval_d   = pval_q;
      cos_en_d = cos_en_q;
      relay_d  = relay_q;
      ien_d    = ien_q;
      pwm_en_d = pwm_en_q;
      pcfg_d   = pcfg_q;
      fdur_d   = fdur_q;
      ecmp_d   = ecmp_q;
      for (int c = 0; c < iio_pkg::NCH; c++) begin
         ecnt_d[c] = ecnt_q[c];
         if (chg[c]) begin
            ecnt_d[c]  = ecnt_q[c] + 16'h1;
            ev.ovf[c]  = (ecnt_q[c] == iio_pkg::CNT_MAX);
            ev.cmp[c]  = (ecnt_q[c] + 16'h1 == ecmp_q[c]);
         end
      end
      st_d     = st_q;
      bvalid_d = bvalid_q & ~S_AXI_BREADY_I;
      bresp_d  = bresp_q;
      if (wr_hs) begin
         bvalid_d = 1'b1;
         bresp_d  = iio_pkg::RESP_OKAY;
         case (wa)
            iio_pkg::OFS_FILT_EN:  fen_d    = 8'(merge_strb({24'h0, fen_q}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
            iio_pkg::OFS_PAT_MASK: pmask_d  = 8'(merge_strb({24'h0, pmask_q}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
            iio_pkg::OFS_PAT_VAL:  pval_d   = 8'(merge_strb({24'h0, pval_q}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
            iio_pkg::OFS_COS_EN:   cos_en_d = 8'(merge_strb({24'h0, cos_en_q}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
            iio_pkg::OFS_RELAY:    relay_d  = 8'(merge_strb({24'h0, relay_q}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
            iio_pkg::OFS_INT_STAT: st_d     = st_q & ~merge_strb('0, S_AXI_WDATA_I, S_AXI_WSTRB_I);
            iio_pkg::OFS_INT_MASK: ien_d    = merge_strb(ien_q, S_AXI_WDATA_I, S_AXI_WSTRB_I);
            iio_pkg::OFS_PWM_CTRL: pwm_en_d = 2'(merge_strb({30'h0, pwm_en_q}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
            iio_pkg::OFS_PWM_A:    pcfg_d[0] = merge_strb(pcfg_q[0], S_AXI_WDATA_I, S_AXI_WSTRB_I);
            iio_pkg::OFS_PWM_B:    pcfg_d[1] = merge_strb(pcfg_q[1], S_AXI_WDATA_I, S_AXI_WSTRB_I);
            default: begin
               case (wa[7:5])
                  iio_pkg::BANK_FILT_N:
                     fdur_d[wa[4:2]] = 16'(merge_strb({16'h0, fdur_q[wa[4:2]]}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
                  iio_pkg::BANK_EV_CMP:
                     ecmp_d[wa[4:2]] = 16'(merge_strb({16'h0, ecmp_q[wa[4:2]]}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
                  // Any write to a counter word clears that counter.
                  iio_pkg::BANK_EV_CNT:
                     ecnt_d[wa[4:2]] = '0;
                  default:
                     bresp_d = iio_pkg::RESP_SLVERR;
               endcase
            end
         endcase
      end
      st_d     = st_d | ev;
      st_d.rsv_hi = '0;
      st_d.rsv_lo = '0;
      ien_d.rsv_hi = '0;
      ien_d.rsv_lo = '0;
      rvalid_d = rvalid_q & ~S_AXI_RREADY_I;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      if (rd_hs) begin
         rvalid_d = 1'b1;
         rresp_d  = iio_pkg::RESP_OKAY;
         rdata_d  = '0;
         case (ra)
            iio_pkg::OFS_DI_STATE: rdata_d = {24'h0, di_q};
            iio_pkg::OFS_FILT_EN:  rdata_d = {24'h0, fen_q};
            iio_pkg::OFS_PAT_MASK: rdata_d = {24'h0, pmask_q};
            iio_pkg::OFS_PAT_VAL:  rdata_d = {24'h0, pval_q};
            iio_pkg::OFS_COS_EN:   rdata_d = {24'h0, cos_en_q};
            iio_pkg::OFS_RELAY:    rdata_d = {24'h0, relay_q};
            iio_pkg::OFS_INT_STAT: rdata_d = st_q;
            iio_pkg::OFS_INT_MASK: rdata_d = ien_q;
            iio_pkg::OFS_PWM_CTRL: rdata_d = {30'h0, pwm_en_q};
            iio_pkg::OFS_PWM_A:    rdata_d = pcfg_q[0];
            iio_pkg::OFS_PWM_B:    rdata_d = pcfg_q[1];
            default: begin
               case (ra[7:5])
                  iio_pkg::BANK_FILT_N: rdata_d = {16'h0, fdur_q[ra[4:2]]};
                  iio_pkg::BANK_EV_CMP: rdata_d = {16'h0, ecmp_q[ra[4:2]]};
                  iio_pkg::BANK_EV_CNT: rdata_d = {16'h0, ecnt_q[ra[4:2]]};
                  default:              rresp_d = iio_pkg::RESP_SLVERR;
               endcase
            end
         endcase
      end
   end

   // Pulse generators; each restarts its own 100 ms prescaler when enabled.
   always_comb begin
      for (int p = 0; p < iio_pkg::NPWM; p++) begin
         pst_d[p]  = pst_q[p];
         pcnt_d[p] = pcnt_q[p];
         ppre_d[p] = '0;
         if (!pwm_en_q[p]) begin
            pst_d[p]  = iio_pkg::PW_IDLE;
            pcnt_d[p] = '0;
         end else begin
            case (pst_q[p])
               iio_pkg::PW_IDLE: begin
                  pst_d[p]  = iio_pkg::PW_HIGH;
                  pcnt_d[p] = '0;
               end
               iio_pkg::PW_HIGH, iio_pkg::PW_LOW: begin
                  ppre_d[p] = (ppre_q[p] == PTICK_LAST) ? '0 : ppre_q[p] + 32'h1;
                  if (ppre_q[p] == PTICK_LAST) begin
                     pcnt_d[p] = pcnt_q[p] + 16'h1;
                     if (pst_q[p] == iio_pkg::PW_HIGH &&
                         pcnt_q[p] + 16'h1 >= at_least(pcfg_q[p].high_n, iio_pkg::PWM_MIN_N)) begin
                        pst_d[p]  = iio_pkg::PW_LOW;
                        pcnt_d[p] = '0;
                     end else if (pst_q[p] == iio_pkg::PW_LOW &&
                         pcnt_q[p] + 16'h1 >= at_least(pcfg_q[p].low_n, iio_pkg::PWM_MIN_N)) begin
                        pst_d[p]  = iio_pkg::PW_HIGH;
                        pcnt_d[p] = '0;
                     end
                  end
               end
               default: pst_d[p] = iio_pkg::PW_IDLE;
            endcase
         end
         pout_d[p] = (pst_d[p] == iio_pkg::PW_HIGH);
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         sync1_q  <= '0;
         sync2_q  <= '0;
         di_q     <= '0;
         fpre_q   <= '0;
         fen_q    <= '0;
         pmask_q  <= '0;
         pval_q   <= '0;
         cos_en_q <= '0;
         relay_q  <= '0;
         match_q  <= 1'b0;
         st_q     <= '0;
         ien_q    <= '0;
         pwm_en_q <= '0;
         pout_q   <= '0;
         bvalid_q <= 1'b0;
         bresp_q  <= iio_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q  <= iio_pkg::RESP_OKAY;
         rdata_q  <= '0;
         for (int c = 0; c < iio_pkg::NCH; c++) begin
            fcnt_q[c] <= '0;
            fdur_q[c] <= iio_pkg::FILT_RST_N;
            ecmp_q[c] <= '0;
            ecnt_q[c] <= '0;
         end
         for (int p = 0; p < iio_pkg::NPWM; p++) begin
            pcfg_q[p] <= '{low_n: iio_pkg::PWM_RST_N, high_n: iio_pkg::PWM_RST_N};
            pst_q[p]  <= iio_pkg::PW_IDLE;
            pcnt_q[p] <= '0;
            ppre_q[p] <= '0;
         end
      end else begin
         sync1_q  <= ISO_IN_I;
         sync2_q  <= sync1_q;
         di_q     <= di_d;
         fpre_q   <= fpre_d;
         fen_q    <= fen_d;
         pmask_q  <= pmask_d;
         pval_q   <= pval_d;
         cos_en_q <= cos_en_d;
         relay_q  <= relay_d;
         match_q  <= match_d;
         st_q     <= st_d;
         ien_q    <= ien_d;
         pwm_en_q <= pwm_en_d;
         pout_q   <= pout_d;
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q  <= rresp_d;
         rdata_q  <= rdata_d;
         fcnt_q   <= fcnt_d;
         fdur_q   <= fdur_d;
         ecmp_q   <= ecmp_d;
         ecnt_q   <= ecnt_d;
         pcfg_q   <= pcfg_d;
         pst_q    <= pst_d;
         pcnt_q   <= pcnt_d;
         ppre_q   <= ppre_d;
      end
   end

endmodule // iio_top

// ---- tb/iio_checker.sv ----
`timescale 1ns/1ps
module iio_checker (
   input wire logic        CLK_I,
   input wire logic        RST_I,
   input wire logic [7:0]  S_AXI_AWADDR_I,
   input wire logic        S_AXI_AWVALID_I,
   input wire logic        S_AXI_AWREADY_O,
   input wire logic        S_AXI_WVALID_I,
   input wire logic        S_AXI_WREADY_O,
   input wire logic [1:0]  S_AXI_BRESP_O,
   input wire logic        S_AXI_BVALID_O,
   input wire logic        S_AXI_BREADY_I,
   input wire logic        S_AXI_ARVALID_I,
   input wire logic        S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic        S_AXI_RVALID_O,
   input wire logic        S_AXI_RREADY_I,
   input wire logic [7:0]  RELAY_O,
   input wire logic        PULSE_OUT_A_O,
   input wire logic        IRQ_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   wire wr_take = S_AXI_AWVALID_I && S_AXI_WVALID_I && S_AXI_AWREADY_O;

   chk_aw_ready: assert property (S_AXI_AWREADY_O == (S_AXI_AWVALID_I && S_AXI_WVALID_I && !S_AXI_BVALID_O)
      && S_AXI_WREADY_O == S_AXI_AWREADY_O) else $error("write ready wrong");
   chk_b_answer: assert property (wr_take |=> S_AXI_BVALID_O) else $error("no write response");
   chk_b_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped");
   chk_unmapped_err: assert property (wr_take && S_AXI_AWADDR_I[7:2] inside {[6'h0B:6'h0F]}
      |=> S_AXI_BRESP_O == iio_pkg::RESP_SLVERR) else $error("unmapped write not refused");
   chk_ar_ready: assert property (S_AXI_ARREADY_O == !S_AXI_RVALID_O) else $error("read ready wrong");
   chk_r_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("no read response");
   chk_r_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
      else $error("read data dropped");
   chk_relay_cause: assert property ($changed(RELAY_O) |-> $past(wr_take))
      else $error("relay moved without write");
   chk_relay_quiet: assert property (!wr_take |=> $stable(RELAY_O)) else $error("relay unstable");

   cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == iio_pkg::RESP_SLVERR);
   cover property ($rose(PULSE_OUT_A_O));
   cover property ($rose(IRQ_O));
endmodule // iio_checker

bind iio_top iio_checker u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .S_AXI_AWADDR_I(S_AXI_AWADDR_I),
   .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
   .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
   .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
   .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
   .RELAY_O(RELAY_O), .PULSE_OUT_A_O(PULSE_OUT_A_O), .IRQ_O(IRQ_O));

// ---- tb/iio_field.sv ----
`timescale 1ns/1ps
module iio_field (
   input  wire logic       clk_i,
   output logic      [7:0] lvl_o
);
   initial lvl_o = 8'h00;

   task automatic set_level(input int ch, input logic v);
      @(posedge clk_i);
      lvl_o[ch] <= v;
   endtask

   // Each phase is held for ph cycles so the counters can follow every edge.
   task automatic burst(input int ch, input int n, input int ph);
      @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         lvl_o[ch] <= ~lvl_o[ch];
         repeat (ph) @(posedge clk_i);
      end
   endtask
endmodule // iio_field

// ---- tb/test_isolated_input_event_and_pwm_io.sv ----
`timescale 1ns/1ps
module test_isolated_input_event_and_pwm_io;
   localparam int TF = 10;
   localparam int TP = 20;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, pa, pb, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [7:0]  relay, iso;
   int          bad_count = 0;
   int          n_compared = 0;

   always #10 clk = ~clk;

   iio_top #(.FILT_TICK_CYC(TF), .PWM_TICK_CYC(TP)) dut (.CLK_I(clk), .RST_I(rst),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .ISO_IN_I(iso), .RELAY_O(relay), .PULSE_OUT_A_O(pa), .PULSE_OUT_B_O(pb), .IRQ_O(irq));
   iio_field field (.clk_i(clk), .lvl_o(iso));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      rd(8'h40, d, r);
      check(d, 32'h2);
      rd(8'h24, d, r);
      check(d, 32'h00010001);
      for (int i = 1; i >= 0; i--) begin
         wr(8'h14, i ? 32'h5A : 32'hA5, r);
         check({24'h0, relay}, i ? 32'h5A : 32'hA5);
      end
      wr(8'h30, 32'h1, r);
      check({30'h0, r}, {30'h0, iio_pkg::RESP_SLVERR});
      rd(8'h30, d, r);
      check({30'h0, r}, {30'h0, iio_pkg::RESP_SLVERR});
      check(d, 32'h0);
      $display("register test done");
   endtask

   task automatic t_filter;
      logic [31:0] d;
      logic [1:0]  r;
      wr(8'h04, 32'h1, r);
      field.set_level(0, 1'b1);
      field.set_level(1, 1'b1);
      repeat (10) @(posedge clk);
      rd(8'h00, d, r);
      check(d & 32'h3, 32'h2);
      repeat (30) @(posedge clk);
      rd(8'h00, d, r);
      check(d & 32'h3, 32'h3);
      $display("filter test done");
   endtask

   task automatic t_count;
      logic [31:0] d;
      logic [1:0]  r;
      wr(8'h64, 32'h3, r);
      wr(8'h1C, 32'h00020000, r);
      wr(8'h84, 32'h0, r);
      field.burst(1, 6, 6);
      rd(8'h84, d, r);
      check(d, 32'h6);
      rd(8'h18, d, r);
      check(d & 32'h00020000, 32'h00020000);
      check({31'h0, irq}, 32'h1);
      wr(8'h18, 32'h00020000, r);
      check({31'h0, irq}, 32'h0);
      $display("counter test done");
   endtask

   task automatic t_cos_pat;
      logic [31:0] d;
      logic [1:0]  r;
      wr(8'h10, 32'h4, r);
      wr(8'h08, 32'h8, r);
      wr(8'h0C, 32'h8, r);
      wr(8'h18, 32'hFFFFFFFF, r);
      wr(8'h1C, 32'h3, r);
      field.set_level(2, 1'b1);
      repeat (6) @(posedge clk);
      rd(8'h18, d, r);
      check(d & 32'h3, 32'h2);
      wr(8'h18, 32'h2, r);
      field.set_level(3, 1'b1);
      repeat (6) @(posedge clk);
      rd(8'h18, d, r);
      check(d & 32'h3, 32'h1);
      check({31'h0, irq}, 32'h1);
      wr(8'h1C, 32'h0, r);
      check({31'h0, irq}, 32'h0);
      $display("match test done");
   endtask

   task automatic t_pulse;
      logic [1:0] r;
      int         n;
      wr(8'h24, {16'h0003, 16'h0002}, r);
      wr(8'h28, {16'h0001, 16'h0001}, r);
      // Both outputs start on the same edge; B toggles every TP cycles.
      wr(8'h20, 32'h3, r);
      do @(posedge clk); while (pa !== 1'b1);
      n = 0;
      do begin @(posedge clk); n++; end while (pa === 1'b1);
      check(n, 2 * TP);
      check({31'h0, pb}, 32'h1);
      n = 0;
      do begin @(posedge clk); n++; end while (pa === 1'b0);
      check(n, 3 * TP);
      check({31'h0, pb}, 32'h0);
      wr(8'h20, 32'h0, r);
      $display("pulse test done");
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_filter();
      t_count();
      t_cos_pat();
      t_pulse();
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule // test_isolated_input_event_and_pwm_io
